// ### lecr_top.sv
// Logical layer error detect, enable and capture registers on AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1: Capture and lock on enabled detected error.
// RULE2: Only hop-zero maintenance packets are checked.
// RULE3: Address capture valid only for requests.
// RULE4: Bad transport type still loads address.
// RULE5: Correct failing request leaves captures unchanged.
// RULE6: Address bits 8-28, word pointer bit 30.
// RULE7: Undefined transport type captures packet bytes 3,4.
// RULE8: Source ID low 24-31, upper 16-23 large.
// RULE9: Format type 0-3, transaction type 4-7.
// RULE10: Captured format type is expected eight.
// RULE11: Software clears control capture writing zero.
// RULE12: Illegal request on bad ttype or tt.
// RULE13: Hop-zero maintenance response flags illegal response.
// RULE14: Hop-zero port-write flags unsupported transaction.
// RULE15: Lock held until detect flags cleared.
module lecr_top
   import lecr_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        SYS_RST,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        PKT_VALID,
   input  wire lecr_pkt_t   PKT,
   output logic             CAPTURE_LOCKED
);

////////////////////////////////////////////////////////////////////////////////

   logic [31:0] det_q;
   logic [31:0] en_q;
   lecr_cap_t   cap_q;
   logic        locked;
   logic        dp_wr;
   logic [15:0] dp_addr;

   // Bus address phase and data phase decode.
   wire         addr_take = HSEL & HREADY & HTRANS[1];
   wire [15:0]  haddr_lo  = HADDR[15:0];
   wire         wr_det    = dp_wr & (dp_addr == LECR_DET_OFS);
   wire         wr_en     = dp_wr & (dp_addr == LECR_EN_OFS);
   wire         wr_addr   = dp_wr & (dp_addr == LECR_ADDR_OFS);
   wire         wr_devid  = dp_wr & (dp_addr == LECR_DEVID_OFS);
   wire         wr_ctrl   = dp_wr & (dp_addr == LECR_CTRL_OFS);
   wire         wr_cap    = wr_addr | wr_devid | wr_ctrl;

   wire [31:0]  rd_data =
      (haddr_lo == LECR_DET_OFS)   ? det_q       :
      (haddr_lo == LECR_EN_OFS)    ? en_q        :
      (haddr_lo == LECR_ADDR_OFS)  ? cap_q.addr  :
      (haddr_lo == LECR_DEVID_OFS) ? cap_q.devid :
      (haddr_lo == LECR_CTRL_OFS)  ? cap_q.ctrl  : LECR_RESET;

////////////////////////////////////////////////////////////////////////////////

   // Packet classification; the receive path can also offer packets with a nonzero
   // hop count here, so the hop and format type are both checked.
   wire pkt_term  = PKT_VALID & (PKT.ftype == LECR_FTYPE_MAINT)
                  & (PKT.hop == LECR_HOP_TERM);               // [RULE2]
   wire tt_bad    = PKT.tt[1];
   wire is_rsp    = (PKT.ttype == LECR_TTYPE_RSP_RD)
                  | (PKT.ttype == LECR_TTYPE_RSP_WR);
   wire is_pw     = PKT.ttype == LECR_TTYPE_PW;
   wire ttype_ill = PKT.ttype >= LECR_TTYPE_ILL_LO;
   wire ev_req    = pkt_term & (ttype_ill | tt_bad);          // [RULE12]
   wire ev_rsp    = pkt_term & ~tt_bad & is_rsp;              // [RULE13]
   wire ev_pw     = pkt_term & ~tt_bad & is_pw;               // [RULE14]

   logic [31:0] ev_vec;
   always_comb begin
      ev_vec               = LECR_RESET;
      ev_vec[LECR_REQ_BIT] = ev_req;
      ev_vec[LECR_RSP_BIT] = ev_rsp;
      ev_vec[LECR_PW_BIT]  = ev_pw;
   end

   // A correctly formatted request raises no event, so nothing is captured.
   wire cap_go = ~locked & (|(ev_vec & en_q)); // [RULE1] [RULE5]

////////////////////////////////////////////////////////////////////////////////

   // Values loaded into the capture registers on an enabled error.
   logic [31:0] next_cap_addr;
   logic [31:0] next_cap_devid;
   logic [31:0] next_cap_ctrl;
   always_comb begin
      next_cap_addr = LECR_RESET;
      // Whatever sits in the address position is taken, even if invalid.
      next_cap_addr[LECR_ADDR_MSB:LECR_ADDR_LSB] =
         PKT.addr;                               // [RULE3] [RULE4] [RULE6]
      next_cap_addr[LECR_WORD_PTR_BIT] = PKT.word_ptr;        // [RULE6]
      next_cap_devid = LECR_RESET;
      if (tt_bad) begin
         next_cap_devid[LECR_SRCHI_LSB +: 8] = PKT.byte3;     // [RULE7]
         next_cap_devid[LECR_SRCLO_LSB +: 8] = PKT.byte4;     // [RULE7]
      end else begin
         next_cap_devid[LECR_SRCLO_LSB +: 8] = PKT.src_lo;    // [RULE8]
         if (PKT.tt == LECR_TT_LARGE) begin
            next_cap_devid[LECR_SRCHI_LSB +: 8] = PKT.src_hi; // [RULE8]
         end
      end
      next_cap_ctrl = LECR_RESET;
      next_cap_ctrl[LECR_FTYPE_LSB +: 4] = PKT.ftype; // [RULE9] [RULE10]
      next_cap_ctrl[LECR_TTYPE_LSB +: 4] = PKT.ttype;         // [RULE9]
   end

   // Detect flags: write zero to clear, a new event wins over the clear.
   wire [31:0] det_clr    = wr_det ? (~HWDATA & LECR_FLAG_MASK) : LECR_RESET;
   wire [31:0] next_det   = (det_q & ~det_clr) | ev_vec;
   // The lock drops once every detect flag has been cleared.
   wire        next_lock  = cap_go | (locked & (|next_det));  // [RULE15]

////////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         dp_wr   <= 1'b0;
         dp_addr <= 16'h0000;
      end else begin
         dp_wr   <= addr_take & HWRITE;
         dp_addr <= haddr_lo;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         HRDATA    <= LECR_RESET;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else begin
         if (addr_take & ~HWRITE) begin
            HRDATA <= rd_data;
         end
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         det_q  <= LECR_RESET;
         en_q   <= LECR_RESET;
         locked <= 1'b0;
      end else begin
         det_q  <= next_det;
         locked <= next_lock;                                 // [RULE1]
         if (wr_en) begin
            en_q <= HWDATA & LECR_FLAG_MASK;
         end
      end
   end

   // Capture registers; hardware capture wins over a software write.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         cap_q <= '0;
      end else if (cap_go) begin
         cap_q.addr  <= next_cap_addr;                        // [RULE1]
         cap_q.devid <= next_cap_devid;
         cap_q.ctrl  <= next_cap_ctrl;
      end else begin
         if (wr_addr) begin
            cap_q.addr <= HWDATA & LECR_ADDR_MASK;
         end
         if (wr_devid) begin
            cap_q.devid <= HWDATA & LECR_DEVID_MASK;
         end
         if (wr_ctrl) begin
            cap_q.ctrl <= HWDATA & LECR_CTRL_MASK;            // [RULE11]
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         CAPTURE_LOCKED <= 1'b0;
      end else begin
         CAPTURE_LOCKED <= next_lock;
      end
   end

////////////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);

   a_capture_locks: assert property ( // [RULE1]
      cap_go |=> locked && CAPTURE_LOCKED
   ) else $error("enabled error did not lock captures");

   a_lock_freezes: assert property ( // [RULE15]
      (locked && !wr_cap) |=> $stable(cap_q)
   ) else $error("locked capture registers changed");

   a_lock_release: assert property ( // [RULE15]
      (locked && next_det == 32'h00000000) |=> !locked && !CAPTURE_LOCKED
   ) else $error("lock not released after flags cleared");

   a_hop_filter: assert property ( // [RULE2]
      (PKT_VALID && PKT.hop != LECR_HOP_TERM && !wr_det)
         |=> det_q == $past(det_q)
   ) else $error("non-terminating packet raised an error");

   a_addr_load: assert property ( // [RULE3]
      cap_go |=> cap_q.addr[LECR_ADDR_MSB:LECR_ADDR_LSB] == $past(PKT.addr)
              && cap_q.addr[LECR_WORD_PTR_BIT] == $past(PKT.word_ptr)
   ) else $error("address capture not loaded from packet");

   a_addr_layout: assert property ( // [RULE6]
      (cap_q.addr & ~LECR_ADDR_MASK) == 32'h00000000
   ) else $error("reserved address capture bits set");

   a_good_req_quiet: assert property ( // [RULE5]
      (pkt_term && !ttype_ill && !tt_bad && !is_rsp && !is_pw && !wr_cap)
         |=> $stable(cap_q) && !$rose(locked)
   ) else $error("good request disturbed the captures");

   a_devid_raw: assert property ( // [RULE7]
      (cap_go && tt_bad) |=> cap_q.devid[23:16] == $past(PKT.byte3)
                           && cap_q.devid[31:24] == $past(PKT.byte4)
   ) else $error("raw bytes not captured for bad transport type");

   a_devid_small: assert property ( // [RULE8]
      (cap_go && PKT.tt == LECR_TT_SMALL)
         |=> cap_q.devid == {$past(PKT.src_lo), 24'h000000}
   ) else $error("small source id capture wrong");

   a_ctrl_fields: assert property ( // [RULE9]
      cap_go |=> cap_q.ctrl == {24'h000000, $past(PKT.ttype), 4'h8}
   ) else $error("control capture fields wrong");

   a_ill_request: assert property ( // [RULE12]
      (pkt_term && (tt_bad || PKT.ttype >= 4'h5)) |=> det_q[4] ##1 1'b1
   ) else $error("illegal request not flagged");

   a_ill_response: assert property ( // [RULE13]
      ev_rsp |=> det_q[8]
   ) else $error("illegal response not flagged");

   a_unsup_pw: assert property ( // [RULE14]
      ev_pw |=> det_q[9]
   ) else $error("hop-zero port-write not flagged");

   a_bus_okay: assert property (
      HREADYOUT && !HRESP
   ) else $error("bus response not ready and okay");

   // Reset, lock and flag bookkeeping.
   a_reset_clears: assert property ( // [RULE1]
      disable iff (1'b0)
      SYS_RST |=> !locked && !CAPTURE_LOCKED && det_q == 32'h00000000
   ) else $error("reset left the lock or flags set");

   a_enable_gate: assert property ( // [RULE1]
      (!locked && (ev_vec & en_q) == 32'h00000000) |=> !locked
   ) else $error("lock set without an enabled error");

   a_lock_holds: assert property ( // [RULE15]
      (locked && next_det != 32'h00000000) |=> locked && CAPTURE_LOCKED
   ) else $error("lock dropped while flags remain");

   a_flag_clear: assert property ( // [RULE15]
      (wr_det && !HWDATA[LECR_REQ_BIT] && !ev_req)
         |=> !det_q[LECR_REQ_BIT]
   ) else $error("illegal request flag not cleared");

   a_flags_quiet: assert property (
      (!PKT_VALID && !wr_det) |=> $stable(det_q)
   ) else $error("detect flags changed with no packet");

   a_rsp_flag: assert property ( // [RULE13]
      (pkt_term && !tt_bad && PKT.ttype == LECR_TTYPE_RSP_WR)
         |=> det_q[LECR_RSP_BIT]
   ) else $error("write response flag missing");

   a_pw_flag: assert property ( // [RULE14]
      (pkt_term && !tt_bad && PKT.ttype == LECR_TTYPE_PW)
         |=> det_q[LECR_PW_BIT]
   ) else $error("port-write flag missing");

   a_det_layout: assert property (
      (det_q & ~LECR_FLAG_MASK) == 32'h00000000
   ) else $error("reserved detect bits set");

   a_en_layout: assert property (
      (en_q & ~LECR_FLAG_MASK) == 32'h00000000
   ) else $error("reserved enable bits set");

   a_en_write: assert property (
      wr_en |=> en_q == ($past(HWDATA) & LECR_FLAG_MASK)
   ) else $error("enable write did not land");

   // Capture layout and software access.
   a_devid_large: assert property ( // [RULE8]
      (cap_go && PKT.tt == LECR_TT_LARGE) |=> cap_q.devid ==
         {$past(PKT.src_lo), $past(PKT.src_hi), 16'h0000}
   ) else $error("large source id capture wrong");

   a_devid_layout: assert property ( // [RULE8]
      cap_q.devid[15:0] == 16'h0000
   ) else $error("reserved source id capture bits set");

   a_ctrl_layout: assert property ( // [RULE9]
      cap_q.ctrl[31:8] == 24'h000000
   ) else $error("reserved control capture bits set");

   a_ftype_eight: assert property ( // [RULE10]
      cap_go |=> cap_q.ctrl[3:0] == LECR_FTYPE_MAINT
   ) else $error("captured format type is not eight");

   a_ctrl_write: assert property ( // [RULE11]
      (wr_ctrl && !cap_go)
         |=> cap_q.ctrl == ($past(HWDATA) & LECR_CTRL_MASK)
   ) else $error("control capture write did not land");

   a_read_ctrl: assert property ( // [RULE9]
      (addr_take && !HWRITE && haddr_lo == LECR_CTRL_OFS)
         |=> HRDATA == $past(cap_q.ctrl)
   ) else $error("control capture read data wrong");

   a_unmapped_read: assert property (
      (addr_take && !HWRITE && haddr_lo == 16'h1010)
         |=> HRDATA == 32'h00000000
   ) else $error("unmapped read returned data");

   c_capture:  cover property (cap_go ##1 locked);
   c_unlock:   cover property (locked ##1 !locked);
   c_ctrl_clr: cover property (locked && wr_ctrl && HWDATA == 32'h0);
   c_bad_tt:   cover property (cap_go && tt_bad);
   c_tt_three: cover property (cap_go && PKT.tt == 2'h3);

endmodule

`default_nettype wire

// ### lecr_pkg.sv
// Register map, field layout and packet carrier of the error capture block.
package lecr_pkg;
   // Byte offsets of the registers.
   localparam logic [15:0] LECR_DET_OFS   = 16'h1008;
   localparam logic [15:0] LECR_EN_OFS    = 16'h100c;
   localparam logic [15:0] LECR_ADDR_OFS  = 16'h1014;
   localparam logic [15:0] LECR_DEVID_OFS = 16'h1018;
   localparam logic [15:0] LECR_CTRL_OFS  = 16'h101c;
   localparam logic [31:0] LECR_RESET     = 32'h00000000;
   // Detect and enable bit positions.
   localparam int          LECR_REQ_BIT   = 4;
   localparam int          LECR_RSP_BIT   = 8;
   localparam int          LECR_PW_BIT    = 9;
   localparam logic [31:0] LECR_FLAG_MASK = 32'h00000310;
   // Capture field positions and writable masks.
   localparam int          LECR_ADDR_LSB  = 8;
   localparam int          LECR_ADDR_MSB  = 28;
   localparam int          LECR_WORD_PTR_BIT = 30;
   localparam int          LECR_SRCLO_LSB = 24;
   localparam int          LECR_SRCHI_LSB = 16;
   localparam int          LECR_FTYPE_LSB = 0;
   localparam int          LECR_TTYPE_LSB = 4;
   localparam logic [31:0] LECR_ADDR_MASK  = 32'h5fffff00;
   localparam logic [31:0] LECR_DEVID_MASK = 32'hffff0000;
   localparam logic [31:0] LECR_CTRL_MASK  = 32'h000000ff;
   // Packet field codes.
   localparam logic [3:0]  LECR_FTYPE_MAINT = 4'h8;
   localparam logic [3:0]  LECR_TTYPE_RSP_RD = 4'h2;
   localparam logic [3:0]  LECR_TTYPE_RSP_WR = 4'h3;
   localparam logic [3:0]  LECR_TTYPE_PW     = 4'h4;
   localparam logic [3:0]  LECR_TTYPE_ILL_LO = 4'h5;
   localparam logic [1:0]  LECR_TT_SMALL     = 2'h0;
   localparam logic [1:0]  LECR_TT_LARGE     = 2'h1;
   localparam logic [7:0]  LECR_HOP_TERM     = 8'h00;
   localparam logic [1:0]  LECR_HTRANS_NONSEQ = 2'h2;

   // Header fields of one received maintenance packet.
   typedef struct packed {
      logic [3:0]  ftype;
      logic [3:0]  ttype;
      logic [1:0]  tt;
      logic [7:0]  hop;
      logic [20:0] addr;
      logic        word_ptr;
      logic [7:0]  src_hi;
      logic [7:0]  src_lo;
      logic [7:0]  byte3;
      logic [7:0]  byte4;
   } lecr_pkt_t;

   // The three capture registers.
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] devid;
      logic [31:0] ctrl;
   } lecr_cap_t;
endpackage

// ### lecr_pkt_src.sv
// Behavioural source of received maintenance packet headers.
`timescale 1ns/1ps
`default_nettype none

module lecr_pkt_src
   import lecr_pkg::*;
(
   input  wire logic clk,
   output logic      valid,
   output lecr_pkt_t pkt
);
   initial begin
      valid = 1'b0;
      pkt   = '0;
   end

   // Sends one header for one cycle; afterwards the fields turn to garbage.
   task automatic send(input lecr_pkt_t p);
      valid <= 1'b1;
      pkt   <= p;
      @(posedge clk);
      valid <= 1'b0;
      pkt   <= ~p;
      @(posedge clk);
   endtask
endmodule

`default_nettype wire

// ### tb_logical_error_capture_regs.sv
// Self-checking bench of the error capture register block.
`timescale 1ns/1ps
`default_nettype none

module tb_logical_error_capture_regs;
   import lecr_pkg::*;

   logic        clk_sys;
   logic        sys_rst;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        pkt_valid;
   lecr_pkt_t   pkt;
   logic        capture_locked;
   int          errors;
   int          samples_checked;
   logic [31:0] rd;

   lecr_top dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
      .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .PKT_VALID(pkt_valid),
      .PKT(pkt), .CAPTURE_LOCKED(capture_locked));

   lecr_pkt_src src (.clk(clk_sys), .valid(pkt_valid), .pkt(pkt));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic test_done();
      if (errors == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One single AHB-Lite transfer followed by one idle cycle.
   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= LECR_HTRANS_NONSEQ;
      haddr  <= a;
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
      hsel <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
      bus(1'b0, {16'h0, a}, 32'h0);
      chk($sformatf("reg %h", a), exp, rd);
   endtask

   function automatic lecr_pkt_t mk(input logic [3:0] ty,
                                    input logic [1:0] tt,
                                    input logic [7:0] hop);
      mk = '{4'h8, ty, tt, hop, 21'h1a5a5a, 1'b1, 8'hc3, 8'h3c,
             8'h96, 8'h69};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #100us;
      errors++;
      test_done();
   end

   initial begin
      logic [15:0] ofs [3];
      logic [31:0] msk [3];
      ofs = '{LECR_ADDR_OFS, LECR_DEVID_OFS, LECR_CTRL_OFS};
      msk = '{32'h5fffff00, 32'hffff0000, 32'h000000ff};
      errors = 0;
      samples_checked = 0;
      sys_rst = 1'b1;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = '0;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      rchk(LECR_DET_OFS, 32'h0);
      rchk(LECR_EN_OFS, 32'h0);
      bus(1'b1, 32'h1010, 32'hffffffff);
      rchk(16'h1010, 32'h0);
      for (int i = 0; i < 3; i++) begin
         rchk(ofs[i], 32'h0);
         bus(1'b1, {16'h0, ofs[i]}, 32'hffffffff);
         rchk(ofs[i], msk[i]);
         bus(1'b1, {16'h0, ofs[i]}, 32'h0);
         rchk(ofs[i], 32'h0);
      end
      bus(1'b1, {16'h0, LECR_EN_OFS}, 32'hffffffff);
      rchk(LECR_EN_OFS, 32'h00000310);
      src.send(mk(4'h5, 2'h1, 8'h01));
      rchk(LECR_DET_OFS, 32'h0);
      src.send(mk(4'h0, 2'h0, 8'h00));
      rchk(LECR_DET_OFS, 32'h0);
      rchk(LECR_CTRL_OFS, 32'h0);
      src.send(mk(4'h5, 2'h1, 8'h00));
      chk("locked", 32'h1, {31'h0, capture_locked});
      rchk(LECR_DET_OFS, 32'h00000010);
      rchk(LECR_ADDR_OFS, 32'h5a5a5a00);
      rchk(LECR_DEVID_OFS, 32'h3cc30000);
      rchk(LECR_CTRL_OFS, 32'h00000058);
      src.send(mk(4'h2, 2'h0, 8'h00));
      rchk(LECR_DET_OFS, 32'h00000110);
      rchk(LECR_CTRL_OFS, 32'h00000058);
      bus(1'b1, {16'h0, LECR_DET_OFS}, 32'h0);
      chk("locked", 32'h0, {31'h0, capture_locked});
      bus(1'b1, {16'h0, LECR_CTRL_OFS}, 32'h0);
      rchk(LECR_CTRL_OFS, 32'h0);
      src.send(mk(4'h0, 2'h2, 8'h00));
      rchk(LECR_DET_OFS, 32'h00000010);
      rchk(LECR_ADDR_OFS, 32'h5a5a5a00);
      rchk(LECR_DEVID_OFS, 32'h69960000);
      rchk(LECR_CTRL_OFS, 32'h00000008);
      bus(1'b1, {16'h0, LECR_DET_OFS}, 32'h0);
      src.send(mk(4'h4, 2'h0, 8'h00));
      rchk(LECR_DET_OFS, 32'h00000200);
      rchk(LECR_DEVID_OFS, 32'h3c000000);
      rchk(LECR_CTRL_OFS, 32'h00000048);
      bus(1'b1, {16'h0, LECR_DET_OFS}, 32'h0);
      bus(1'b1, {16'h0, LECR_EN_OFS}, 32'h0);
      src.send(mk(4'h3, 2'h1, 8'h00));
      rchk(LECR_DET_OFS, 32'h00000100);
      chk("locked", 32'h0, {31'h0, capture_locked});
      rchk(LECR_CTRL_OFS, 32'h00000048);
      bus(1'b1, {16'h0, LECR_EN_OFS}, 32'hffffffff);
      src.send(mk(4'hf, 2'h3, 8'h00));
      chk("locked", 32'h1, {31'h0, capture_locked});
      rchk(LECR_DET_OFS, 32'h00000110);
      rchk(LECR_DEVID_OFS, 32'h69960000);
      rchk(LECR_CTRL_OFS, 32'h000000f8);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      chk("locked", 32'h0, {31'h0, capture_locked});
      rchk(LECR_DET_OFS, 32'h0);
      rchk(LECR_EN_OFS, 32'h0);
      rchk(LECR_CTRL_OFS, 32'h0);
      test_done();
   end
endmodule

`default_nettype wire
